//--- logic/cssc_pkg.sv
// Purpose: Shared constants and types of the codec serial slot controller
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes: Byte offsets below are the register map seen by software
package cssc_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BIT_CLOCK_DIVIDER = 8'h04;
    localparam logic [7:0] ADDR_SERIAL_LINK_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RECEIVE_SLOT_MASK = 8'h0C;
    localparam logic [7:0] ADDR_TRANSMIT_SLOT_MASK = 8'h10;
    localparam logic [7:0] ADDR_TX_DATA = 8'h14;
    localparam logic [7:0] ADDR_RX_DATA = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;

    // Field positions and sizes
    localparam int BIT_CLOCK_WIDTH = 12;
    localparam int CTRL_WIDTH = 14;
    localparam int STAT_SLOT_LSB = 8;
    localparam int STAT_ROV_BIT = 3;
    localparam int STAT_RX_FULL_FLAG_BIT = 2;
    localparam int STAT_TX_UNDERFLOW_FLAG_BIT = 1;
    localparam int STAT_TX_EMPTY_FLAG_BIT = 0;
    localparam int BUF_WORDS = 4;
    localparam int SLOT_COUNT = 16;
    localparam int PIN_COUNT = 3;

    // Smallest legal word size code (4 bits per word)
    localparam logic [3:0] MIN_WORD_SIZE = 4'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Reset values
    localparam logic [BIT_CLOCK_WIDTH-1:0] BIT_CLOCK_RST = 12'h000;
    localparam logic [15:0] SLOT_MASK_RST = 16'h0000;
    localparam logic [3:0] IRQ_RST = 4'h0;

    // Control register layout, top bit down to bit 0
    typedef struct packed {
        logic [1:0] bufferDepthSelect;
        logic [3:0] frameWordCount;
        logic [3:0] wordSize;
        logic underflowFillMode;
        logic idleSlotOutputMode;
        logic extClock;
        logic enable;
    } cssc_ctrl_t;

    localparam cssc_ctrl_t CTRL_RST = '0;

    // Status flags, same layout for interrupt status, enable and clear
    typedef struct packed {
        logic rxOverflowFlag;
        logic rxFullFlag;
        logic txUnderflowFlag;
        logic txEmptyFlag;
    } cssc_flags_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b10
    } cssc_state_t;

endpackage : cssc_pkg

//--- logic/cssc_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to sys_clk
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
module cssc_pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pinRaw,
    output logic [WIDTH-1:0] pinClean
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    // Stage one feeds only stage two, so metastability stays contained
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_pin
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    stage1_r[i] <= 1'b0;
                    stage2_r[i] <= 1'b0;
                    stage3_r[i] <= 1'b0;
                    pinClean[i] <= 1'b0;
                end else begin
                    stage1_r[i] <= pinRaw[i];
                    stage2_r[i] <= stage1_r[i];
                    stage3_r[i] <= stage2_r[i];
                    if (stage2_r[i] == stage3_r[i]) begin
                        pinClean[i] <= stage3_r[i];
                    end
                end
            end
        end
    endgenerate

endmodule : cssc_pin_sync

//--- logic/cssc_top.sv
// Purpose: Slot control, status and serial engine of a framed codec port
// Assumes: sys_clk 25 MHz, synchronous active-high rst, AHB-Lite registers
// Notes: Data change on serial clock rise, sampled on fall
// Overview of operation
// - Twelve-bit bit clock setting, upper bits zero
// - Status reports active slot in bits 11:8
// - Receive overflow flag in status bit 3
// - Receive full flag when the selected buffer depth of words waits
// - Transmit underflow flag in status bit 1
// - Transmit empty flag while holding registers empty
// - Receive mask bit enables capture per slot
// - Transmit mask bit enables shifting per slot
// - Disabled transmit slot tri-stated or driven low
// - Output mode one tri-states, zero drives zeros
// - Underflow resends last word or sends zeros
// - Frame length is field value plus one
// - Buffer one to four words between interrupts
`timescale 1ns/1ps
module cssc_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic serialClockIn,
    input wire logic frameSyncIn,
    input wire logic serialDataIn,
    output logic serialClockOut,
    output logic serialClockOutEnN,
    output logic frameSyncOut,
    output logic frameSyncOutEnN,
    output logic serialDataOut,
    output logic serialDataOutEnN,
    output logic irq
);
    import cssc_pkg::*;

    // Pick one slot's enable bit; shared by receive and transmit
    function automatic logic slotBit(input logic [15:0] mask, input logic [3:0] slot);
        slotBit = mask[slot];
    endfunction : slotBit

    logic [PIN_COUNT-1:0] pinClean;
    logic sclkSync, fsSync, sdiSync;

    cssc_pin_sync #(.WIDTH(PIN_COUNT)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pinRaw({serialClockIn, frameSyncIn, serialDataIn}),
        .pinClean(pinClean)
    );
    assign {sclkSync, fsSync, sdiSync} = pinClean;

    // Register and buffer state
    cssc_ctrl_t ctrl_r, ctrl_nxt;
    logic [BIT_CLOCK_WIDTH-1:0] bitClock_r, bitClock_nxt;
    logic [15:0] rxMask_r, rxMask_nxt, txMask_r, txMask_nxt;
    cssc_flags_t flags_r, flags_nxt, irqStat_r, irqStat_nxt, irqEn_r, irqEn_nxt;
    logic [15:0] rxBuf_r [BUF_WORDS], rxBuf_nxt [BUF_WORDS];
    logic [15:0] txBuf_r [BUF_WORDS], txBuf_nxt [BUF_WORDS];
    logic [2:0] rxCnt_r, rxCnt_nxt, txCnt_r, txCnt_nxt;
    logic [1:0] rxRd_r, rxRd_nxt, txRd_r, txRd_nxt;
    logic [15:0] lastTx_r, lastTx_nxt;
    logic pend_r, pend_nxt, pendWrite_r, pendWrite_nxt;
    logic [7:0] pendAddr_r, pendAddr_nxt;
    logic hreadyout_nxt, irq_nxt;
    logic [31:0] hrdata_nxt;

    // Serial engine state
    cssc_state_t state_r, state_nxt;
    logic [3:0] slot_r, slot_nxt, bitCnt_r, bitCnt_nxt;
    logic [BIT_CLOCK_WIDTH-1:0] divCnt_r, divCnt_nxt;
    logic sclkPrev_r, sclkPrev_nxt;
    logic txOn_r, txOn_nxt, rxOn_r, rxOn_nxt;
    logic [15:0] txWord_r, txWord_nxt, rxShift_r, rxShift_nxt;
    logic sclkOut_nxt, fsOut_nxt, sdo_nxt, sdoEnN_nxt, clkEnN_nxt, fsEnN_nxt;
    logic txPop, rxPush, riseEv, fallEv, doLoad, fsSample;
    logic [15:0] pushWord;
    logic [3:0] loadSlot, wordTop;

    logic addrPhase;
    assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);

    // Bus slave, registers, holding buffers and flags
    always_comb begin
        logic [2:0] depth;
        logic [7:0] a;
        cssc_flags_t ev;
        logic rdPop, wrTx;
        depth = {1'b0, ctrl_r.bufferDepthSelect} + 3'h1;
        a = pendAddr_r;
        ev = '0;
        ctrl_nxt = ctrl_r;
        bitClock_nxt = bitClock_r;
        rxMask_nxt = rxMask_r;
        txMask_nxt = txMask_r;
        flags_nxt = flags_r;
        irqStat_nxt = irqStat_r;
        irqEn_nxt = irqEn_r;
        rxBuf_nxt = rxBuf_r;
        txBuf_nxt = txBuf_r;
        rxCnt_nxt = rxCnt_r;
        txCnt_nxt = txCnt_r;
        rxRd_nxt = rxRd_r;
        txRd_nxt = txRd_r;
        lastTx_nxt = lastTx_r;
        pend_nxt = 1'b0;
        pendWrite_nxt = pendWrite_r;
        pendAddr_nxt = pendAddr_r;
        hreadyout_nxt = 1'b1;
        hrdata_nxt = hrdata;
        rdPop = 1'b0;
        wrTx = 1'b0;
        // One wait state lets read data come from a flip-flop
        if (addrPhase) begin
            pend_nxt = 1'b1;
            pendWrite_nxt = hwrite;
            pendAddr_nxt = haddr[7:0];
            hreadyout_nxt = 1'b0;
        end
        if (pend_r && pendWrite_r) begin
            unique case (a)
                ADDR_CTRL: ctrl_nxt = cssc_ctrl_t'(hwdata[CTRL_WIDTH-1:0]);
                ADDR_BIT_CLOCK_DIVIDER: bitClock_nxt = hwdata[BIT_CLOCK_WIDTH-1:0];
                ADDR_RECEIVE_SLOT_MASK: rxMask_nxt = hwdata[15:0];
                ADDR_TRANSMIT_SLOT_MASK: txMask_nxt = hwdata[15:0];
                ADDR_TX_DATA: wrTx = 1'b1;
                ADDR_IRQ_ENABLE: irqEn_nxt = cssc_flags_t'(hwdata[3:0]);
                ADDR_IRQ_CLEAR: irqStat_nxt = irqStat_r & ~cssc_flags_t'(hwdata[3:0]);
                default: ; // Status is read-only, other addresses ignored
            endcase
        end
        if (pend_r && !pendWrite_r) begin
            unique case (a)
                ADDR_CTRL: hrdata_nxt = {18'h0, ctrl_r};
                ADDR_BIT_CLOCK_DIVIDER: hrdata_nxt = {20'h0, bitClock_r};
                ADDR_SERIAL_LINK_STATUS: hrdata_nxt = {20'h0, slot_r, 4'h0, flags_r};
                ADDR_RECEIVE_SLOT_MASK: hrdata_nxt = {16'h0, rxMask_r};
                ADDR_TRANSMIT_SLOT_MASK: hrdata_nxt = {16'h0, txMask_r};
                ADDR_RX_DATA: begin
                    hrdata_nxt = {16'h0, rxBuf_r[rxRd_r]};
                    rdPop = flags_r.rxFullFlag;
                end
                ADDR_IRQ_ENABLE: hrdata_nxt = {28'h0, irqEn_r};
                ADDR_IRQ_STATUS: hrdata_nxt = {28'h0, irqStat_r};
                default: hrdata_nxt = 32'h0;
            endcase
        end
        // Reading the last buffered word while full frees the receive buffer; reads when not full do not pop
        if (rdPop) begin
            if ({1'b0, rxRd_r} + 3'h1 == rxCnt_r) begin
                rxRd_nxt = 2'h0;
                rxCnt_nxt = 3'h0;
                flags_nxt.rxFullFlag = 1'b0;
                flags_nxt.rxOverflowFlag = 1'b0;
            end else begin
                rxRd_nxt = rxRd_r + 2'h1;
            end
        end
        // Word from the link: store, or overflow when still full
        if (rxPush) begin
            if (flags_nxt.rxFullFlag) begin
                flags_nxt.rxOverflowFlag = 1'b1;
                ev.rxOverflowFlag = 1'b1;
            end else begin
                // A pop that just emptied the buffer frees index zero for this word
                rxBuf_nxt[rxCnt_nxt[1:0]] = pushWord;
                rxCnt_nxt = rxCnt_nxt + 3'h1;
                if (rxCnt_nxt >= depth) begin
                    flags_nxt.rxFullFlag = 1'b1;
                    ev.rxFullFlag = 1'b1;
                end
            end
        end
        // Slot takes a word; an empty buffer is an underflow
        if (txPop) begin
            if (txCnt_r == 3'h0) begin
                ev.txUnderflowFlag = 1'b1;
            end else if ({1'b0, txRd_r} + 3'h1 == txCnt_r) begin
                txRd_nxt = 2'h0;
                txCnt_nxt = 3'h0;
                ev.txEmptyFlag = 1'b1;
            end else begin
                txRd_nxt = txRd_r + 2'h1;
            end
        end
        // Writes beyond the selected depth are dropped
        if (wrTx && txCnt_nxt < depth) begin
            txBuf_nxt[txCnt_nxt[1:0]] = hwdata[15:0];
            txCnt_nxt = txCnt_nxt + 3'h1;
            lastTx_nxt = hwdata[15:0];
            flags_nxt.txUnderflowFlag = 1'b0;
        end
        // Underflow set wins over the clear by a write
        if (ev.txUnderflowFlag) begin
            flags_nxt.txUnderflowFlag = 1'b1;
        end
        flags_nxt.txEmptyFlag = (txCnt_nxt == 3'h0);
        irqStat_nxt = irqStat_nxt | ev;
        irq_nxt = |(irqStat_r & irqEn_r);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            bitClock_r <= BIT_CLOCK_RST;
            rxMask_r <= SLOT_MASK_RST;
            txMask_r <= SLOT_MASK_RST;
            flags_r <= cssc_flags_t'(4'h1);
            irqStat_r <= IRQ_RST;
            irqEn_r <= IRQ_RST;
            for (int i = 0; i < BUF_WORDS; i++) begin
                rxBuf_r[i] <= 16'h0000;
                txBuf_r[i] <= 16'h0000;
            end
            rxCnt_r <= 3'h0;
            txCnt_r <= 3'h0;
            rxRd_r <= 2'h0;
            txRd_r <= 2'h0;
            lastTx_r <= 16'h0000;
            pend_r <= 1'b0;
            pendWrite_r <= 1'b0;
            pendAddr_r <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
            irq <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            bitClock_r <= bitClock_nxt;
            rxMask_r <= rxMask_nxt;
            txMask_r <= txMask_nxt;
            flags_r <= flags_nxt;
            irqStat_r <= irqStat_nxt;
            irqEn_r <= irqEn_nxt;
            rxBuf_r <= rxBuf_nxt;
            txBuf_r <= txBuf_nxt;
            rxCnt_r <= rxCnt_nxt;
            txCnt_r <= txCnt_nxt;
            rxRd_r <= rxRd_nxt;
            txRd_r <= txRd_nxt;
            lastTx_r <= lastTx_nxt;
            pend_r <= pend_nxt;
            pendWrite_r <= pendWrite_nxt;
            pendAddr_r <= pendAddr_nxt;
            hreadyout <= hreadyout_nxt;
            hrdata <= hrdata_nxt;
            hresp <= 1'b0;
            irq <= irq_nxt;
        end
    end

    // Bit clock edges: internal divider or the synchronised pin
    always_comb begin
        logic divTc;
        divTc = (divCnt_r == bitClock_r);
        if (ctrl_r.extClock) begin
            riseEv = sclkSync && !sclkPrev_r;
            fallEv = !sclkSync && sclkPrev_r;
        end else begin
            riseEv = divTc && !serialClockOut;
            fallEv = divTc && serialClockOut;
        end
        fsSample = ctrl_r.extClock ? fsSync : frameSyncOut;
        wordTop = (ctrl_r.wordSize < MIN_WORD_SIZE) ? MIN_WORD_SIZE : ctrl_r.wordSize;
    end

    // Serial engine: slot counting, capture and shifting
    always_comb begin
        state_nxt = state_r;
        slot_nxt = slot_r;
        bitCnt_nxt = bitCnt_r;
        divCnt_nxt = divCnt_r;
        sclkPrev_nxt = sclkSync;
        txOn_nxt = txOn_r;
        rxOn_nxt = rxOn_r;
        txWord_nxt = txWord_r;
        rxShift_nxt = rxShift_r;
        sclkOut_nxt = serialClockOut;
        fsOut_nxt = frameSyncOut;
        sdo_nxt = serialDataOut;
        sdoEnN_nxt = serialDataOutEnN;
        clkEnN_nxt = !(ctrl_r.enable && !ctrl_r.extClock);
        fsEnN_nxt = clkEnN_nxt;
        txPop = 1'b0;
        rxPush = 1'b0;
        pushWord = 16'h0000;
        doLoad = 1'b0;
        loadSlot = 4'h0;
        if (!ctrl_r.enable) begin
            state_nxt = ST_IDLE;
            slot_nxt = 4'h0;
            divCnt_nxt = '0;
            sclkOut_nxt = 1'b0;
            fsOut_nxt = 1'b0;
            sdo_nxt = 1'b0;
            sdoEnN_nxt = 1'b1;
            txOn_nxt = 1'b0;
            rxOn_nxt = 1'b0;
        end else begin
            // Outside enabled transmit slots the idle mode applies at once, not from the next bit
            if (!txOn_r) begin
                sdo_nxt = 1'b0;
                sdoEnN_nxt = ctrl_r.idleSlotOutputMode;
            end
            if (!ctrl_r.extClock) begin
                if (divCnt_r == bitClock_r) begin
                    divCnt_nxt = '0;
                    sclkOut_nxt = !serialClockOut;
                end else begin
                    divCnt_nxt = divCnt_r + 12'h001;
                end
            end
            // Sample edge: capture enabled slots, detect frame sync
            if (fallEv) begin
                if (state_r == ST_RUN && rxOn_r) begin
                    rxShift_nxt = {rxShift_r[14:0], sdiSync};
                    if (bitCnt_r == 4'h0) begin
                        rxPush = 1'b1;
                        pushWord = {rxShift_r[14:0], sdiSync};
                    end
                end
                if (fsSample) begin
                    state_nxt = ST_WAIT;
                end
            end
            // Drive edge: advance bit and slot counters
            if (riseEv) begin
                unique case (state_r)
                    ST_IDLE: ;
                    ST_WAIT: begin
                        state_nxt = ST_RUN;
                        doLoad = 1'b1;
                        loadSlot = 4'h0;
                    end
                    ST_RUN: begin
                        if (bitCnt_r != 4'h0) begin
                            bitCnt_nxt = bitCnt_r - 4'h1;
                        end else if (slot_r == ctrl_r.frameWordCount) begin
                            state_nxt = ST_IDLE;
                            txOn_nxt = 1'b0;
                        end else begin
                            doLoad = 1'b1;
                            loadSlot = slot_r + 4'h1;
                        end
                    end
                    default: state_nxt = ST_IDLE;
                endcase
                if (doLoad) begin
                    slot_nxt = loadSlot;
                    bitCnt_nxt = wordTop;
                    rxShift_nxt = 16'h0000;
                    rxOn_nxt = slotBit(rxMask_r, loadSlot);
                    txOn_nxt = slotBit(txMask_r, loadSlot);
                    txPop = txOn_nxt;
                    if (txCnt_r != 3'h0) begin
                        txWord_nxt = txBuf_r[txRd_r];
                    end else begin
                        txWord_nxt = ctrl_r.underflowFillMode ? lastTx_r : 16'h0000;
                    end
                end
                if (state_nxt == ST_RUN && txOn_nxt) begin
                    sdo_nxt = txWord_nxt[bitCnt_nxt];
                    sdoEnN_nxt = 1'b0;
                end else begin
                    sdo_nxt = 1'b0;
                    sdoEnN_nxt = ctrl_r.idleSlotOutputMode;
                end
                fsOut_nxt = (state_nxt == ST_IDLE) ||
                    (state_nxt == ST_RUN && bitCnt_nxt == 4'h0 && slot_nxt == ctrl_r.frameWordCount);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            slot_r <= 4'h0;
            bitCnt_r <= 4'h0;
            divCnt_r <= '0;
            sclkPrev_r <= 1'b0;
            txOn_r <= 1'b0;
            rxOn_r <= 1'b0;
            txWord_r <= 16'h0000;
            rxShift_r <= 16'h0000;
            serialClockOut <= 1'b0;
            serialClockOutEnN <= 1'b1;
            frameSyncOut <= 1'b0;
            frameSyncOutEnN <= 1'b1;
            serialDataOut <= 1'b0;
            serialDataOutEnN <= 1'b1;
        end else begin
            state_r <= state_nxt;
            slot_r <= slot_nxt;
            bitCnt_r <= bitCnt_nxt;
            divCnt_r <= divCnt_nxt;
            sclkPrev_r <= sclkPrev_nxt;
            txOn_r <= txOn_nxt;
            rxOn_r <= rxOn_nxt;
            txWord_r <= txWord_nxt;
            rxShift_r <= rxShift_nxt;
            serialClockOut <= sclkOut_nxt;
            serialClockOutEnN <= clkEnN_nxt;
            frameSyncOut <= fsOut_nxt;
            frameSyncOutEnN <= fsEnN_nxt;
            serialDataOut <= sdo_nxt;
            serialDataOutEnN <= sdoEnN_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence seq_addr_taken;
        hsel && hready && htrans == HTRANS_NONSEQ;
    endsequence
    sequence seq_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    AST_BUS_ONE_WAIT: assert property (seq_addr_taken |=> seq_one_wait)
        else $error("Data phase not one wait state");
    AST_DIVIDER_UPPER_ZERO: assert property (pend_r && !pendWrite_r && pendAddr_r == ADDR_BIT_CLOCK_DIVIDER
        |=> hrdata[31:12] == 20'h0) else $error("Divider upper bits not zero");
    AST_SLOT_IN_FRAME: assert property (state_r == ST_RUN |-> slot_r <= ctrl_r.frameWordCount)
        else $error("Slot beyond frame length");
    AST_OVERFLOW_SET: assert property (rxPush && flags_r.rxFullFlag && !(pend_r && !pendWrite_r)
        |=> flags_r.rxOverflowFlag) else $error("Overflow not flagged");
    AST_FULL_HAS_DATA: assert property (flags_r.rxFullFlag |-> rxCnt_r != 3'h0)
        else $error("Full with no data");
    AST_UNDERFLOW_SET: assert property (txPop && txCnt_r == 3'h0 |=> flags_r.txUnderflowFlag)
        else $error("Underflow not flagged");
    AST_EMPTY_MATCH: assert property (flags_r.txEmptyFlag == (txCnt_r == 3'h0))
        else $error("Empty flag wrong");
    AST_RX_MASK: assert property (rxPush |-> rxMask_r[slot_r])
        else $error("Capture in disabled slot");
    AST_IDLE_DRIVE_ZERO: assert property (!serialDataOutEnN && !txOn_r |-> !serialDataOut)
        else $error("Disabled slot not driven low");
    AST_TRISTATE_MODE: assert property (ctrl_r.enable && serialDataOutEnN && $stable(ctrl_r)
        |-> ctrl_r.idleSlotOutputMode) else $error("Tri-state without output mode");
    AST_FRAME_START: assert property (riseEv && state_r == ST_WAIT && ctrl_r.enable
        |=> slot_r == 4'h0 && bitCnt_r == wordTop) else $error("Frame did not start at slot 0");

endmodule : cssc_top

//--- tb/cssc_codec_model.sv
// Purpose: Codec model on the far side of the serial link
// Assumes: External clock mode, 320 ns bit, sync bit before slot 0
// Notes: Clock stands still between frames; data sampled late in the bit to cover the pin synchroniser
`timescale 1ns/1ps
module cssc_codec_model (
    output logic sClk,
    output logic fSync,
    output logic sData,
    input wire logic dOut,
    input wire logic dOutEnN
);
    // Idle link until the first frame
    initial begin
        sClk = 1'b0;
        fSync = 1'b0;
        sData = 1'b0;
    end
    // Sync bit, eight data bits, one trailing bit; data change on rise
    task automatic frame(input logic [7:0] tx, output logic [7:0] rx, output logic [7:0] en);
        for (int i = -1; i < 9; i++) begin
            sClk = 1'b1;
            fSync = (i < 0);
            sData = (i >= 0 && i < 8) ? tx[7 - i] : ~sData; // Unused bits toggle, no stale value
            #160 sClk = 1'b0;
            #150;
            if (i >= 0 && i < 8) begin
                en[7 - i] = dOutEnN;
                rx[7 - i] = dOutEnN ? 1'b0 : dOut;
            end
            #10;
        end
    endtask : frame
endmodule : cssc_codec_model

//--- tb/codec_serial_slot_control_bench.sv
// Purpose: Self-checking bench of the slot controller
// Assumes: AHB-Lite master tasks, codec model in external clock mode
// Notes: Two-word frames of four bits keep runs short
`timescale 1ns/1ps
module codec_serial_slot_control_bench;
    import cssc_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, irq, sck, fs, sdi, sdo, sdoEnN, sckEnN;
    logic [7:0] gotD, gotE;
    int fails = 0, checkCount = 0, cycles = 0;
    cssc_top dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
        .serialClockIn(sck), .frameSyncIn(fs), .serialDataIn(sdi), .serialClockOut(), .serialClockOutEnN(sckEnN),
        .frameSyncOut(), .frameSyncOutEnN(), .serialDataOut(sdo), .serialDataOutEnN(sdoEnN), .irq(irq));
    cssc_codec_model codec (.sClk(sck), .fSync(fs), .sData(sdi), .dOut(sdo), .dOutEnN(sdoEnN));
    // Clock and hang guard
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            wrapUp();
        end
    end
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One single transfer; waits for hready in both phases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(what, q & m, e);
    endtask : rchk
    // Codec sends A then 3; compares what the block put on the wire
    task automatic run(input logic [7:0] d, input logic [7:0] e);
        codec.frame(8'hA3, gotD, gotE);
        repeat (20) @(posedge sys_clk);
        chk("sdo", {24'h0, gotD}, {24'h0, d});
        chk("sdo off", {24'h0, gotE}, {24'h0, e});
    endtask : run
    task automatic testRegs;
        rchk("stat", ADDR_SERIAL_LINK_STATUS, 32'hFFFFFFFF, 32'h1);
        bus(1'b1, ADDR_BIT_CLOCK_DIVIDER, 32'hFFFFFFFF);
        rchk("div", ADDR_BIT_CLOCK_DIVIDER, 32'hFFFFFFFF, 32'hFFF);
        bus(1'b1, ADDR_SERIAL_LINK_STATUS, 32'hFFFFFFFF);
        rchk("stat", ADDR_SERIAL_LINK_STATUS, 32'hFFFFFFFF, 32'h1);
        rchk("gap", 8'hFC, 32'hFFFFFFFF, 32'h0);
        $display("regs done");
    endtask : testRegs
    task automatic testRx;
        bus(1'b1, ADDR_RECEIVE_SLOT_MASK, 32'h3);
        bus(1'b1, ADDR_IRQ_ENABLE, 32'h4);
        bus(1'b1, ADDR_CTRL, 32'h1133);
        run(8'h00, 8'h00);
        rchk("full", ADDR_SERIAL_LINK_STATUS, 32'hFF, 32'h5);
        rchk("slot", ADDR_SERIAL_LINK_STATUS, 32'hF00, 32'h100);
        chk("irq", {31'h0, irq}, 32'h1);
        rchk("rx0", ADDR_RX_DATA, 32'hFFFF, 32'hA);
        rchk("rx1", ADDR_RX_DATA, 32'hFFFF, 32'h3);
        bus(1'b1, ADDR_RECEIVE_SLOT_MASK, 32'h2);
        bus(1'b1, ADDR_IRQ_CLEAR, 32'hF);
        run(8'h00, 8'h00);
        rchk("half", ADDR_SERIAL_LINK_STATUS, 32'hFF, 32'h1);
        chk("irq", {31'h0, irq}, 32'h0);
        run(8'h00, 8'h00);
        run(8'h00, 8'h00);
        rchk("ovf", ADDR_SERIAL_LINK_STATUS, 32'hFF, 32'hD);
        rchk("rx0", ADDR_RX_DATA, 32'hFFFF, 32'h3);
        rchk("rx1", ADDR_RX_DATA, 32'hFFFF, 32'h3);
        rchk("drain", ADDR_SERIAL_LINK_STATUS, 32'hFF, 32'h1);
        $display("rx done");
    endtask : testRx
    task automatic testTx;
        bus(1'b1, ADDR_RECEIVE_SLOT_MASK, 32'h0);
        bus(1'b1, ADDR_TRANSMIT_SLOT_MASK, 32'h2);
        bus(1'b1, ADDR_CTRL, 32'h113B);
        bus(1'b1, ADDR_TX_DATA, 32'h5);
        rchk("load", ADDR_SERIAL_LINK_STATUS, 32'hF, 32'h0);
        run(8'h05, 8'h00);
        rchk("sent", ADDR_SERIAL_LINK_STATUS, 32'h3, 32'h1);
        run(8'h05, 8'h00);
        rchk("unf", ADDR_SERIAL_LINK_STATUS, 32'h3, 32'h3);
        bus(1'b1, ADDR_CTRL, 32'h1137);
        run(8'h00, 8'hF0);
        $display("tx done");
    endtask : testTx
    // Own bit clock: the word written clears underflow, one frame sends it, the next underflows
    task automatic testInt;
        bus(1'b1, ADDR_TX_DATA, 32'h9);
        bus(1'b1, ADDR_BIT_CLOCK_DIVIDER, 32'h1);
        bus(1'b1, ADDR_CTRL, 32'h1131);
        repeat (100) @(posedge sys_clk);
        chk("clk drive", {31'h0, sckEnN}, 32'h0);
        rchk("int", ADDR_SERIAL_LINK_STATUS, 32'h3, 32'h3);
        $display("int done");
    endtask : testInt
    task automatic wrapUp;
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrapUp
    // Reset for four cycles, then the tests in turn
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        testRegs();
        testRx();
        testTx();
        testInt();
        wrapUp();
    end
endmodule : codec_serial_slot_control_bench
